/* pkg/flow_cfg.svh */
// Purpose: Offsets, field positions, reset values and fixed figures of the flow classifier
// Assumes: Byte addresses on a 9-bit register port, one 32-bit word per register
// Notes: Included by the package and by the testbench
`ifndef FLOW_CFG_SVH
`define FLOW_CFG_SVH

`define FLOWS 8
`define LANES 2
`define ADDR_W 9

`define GLOBAL_OFS 9'h000
`define STATUS_OFS 9'h004
`define FLOW_BASE 9'h040
`define FLOW_STRIDE 9'h020
`define FLOW_SLOT_FIRST 4'h2

`define W_CTRL 3'h0
`define W_ADDR_LO 3'h1
`define W_ADDR_HI 3'h2
`define W_FIRST 3'h3
`define W_SECOND 3'h4
`define W_RANGE 3'h5

`define CTRL_ON_BIT 0
`define CTRL_LANE_LSB 1
`define CTRL_COUNT_LSB 3
`define CTRL_K1_BIT 5
`define CTRL_K2_BIT 6
`define CTRL_LT_BIT 7
`define CTRL_VERIFY_BIT 8
`define CTRL_RANGE_LSB 9
`define CTRL_WHICH_LSB 11
`define CTRL_KIND_LSB 13
`define HI_LSB 16
`define GLB_PBB_BIT 16
`define STAT_LANE_BIT 8
`define STAT_COUNT_LSB 16

`define TPID_RESET 16'h0000
`define PBB_RESET 1'b0
`define CTAG_TPID 16'h8100
`define ITAG_TPID 16'h88e7
`define LENGTH_LIMIT 16'h0600

`endif

/* pkg/flow_pkg.sv */
// Purpose: Types shared by the flow classifier modules
// Assumes: Figures come from flow_cfg.svh
// Notes: Tag info holds a 12-bit identifier in its low bits, or a 24-bit I-tag SID
`include "flow_cfg.svh"
package flow_pkg;
	typedef struct packed {
		logic [15:0] tpid;
		logic [23:0] info;
	} vlan_tag_t;

	typedef struct packed {
		logic valid;
		logic lane;
		logic [47:0] dest_addr;
		logic [47:0] src_addr;
		logic [1:0] tag_count;
		vlan_tag_t tag1;
		vlan_tag_t tag2;
		logic [15:0] type_len;
		logic snap_llc_seen;
	} frame_hdr_t;

	typedef struct packed {
		logic flow_slot_on;
		logic [`LANES-1:0] flow_lane_select;
		logic [1:0] expected_tag_count;
		logic first_tag_kind;
		logic second_tag_kind;
		logic length_type_handling;
		logic tag_value_check_on;
		logic [1:0] tag_range_select;
		logic [1:0] station_addr_which;
		logic [2:0] station_addr_kind;
		logic [47:0] station_addr_value;
		logic [11:0] first_tag_value;
		logic [11:0] first_tag_care_bits;
		logic [11:0] second_tag_value;
		logic [11:0] second_tag_care_bits;
		logic [11:0] tag_range_high;
		logic [11:0] tag_range_low;
	} flow_cfg_t;
endpackage : flow_pkg

/* verilog/flow_match_unit.sv */
// Purpose: Combinational check of one frame header against one flow set
// Assumes: Header fields settle in the cycle the valid bit is high
// Notes: Result is registered by the caller
module flow_match_unit import flow_pkg::*; (
	// Flow set and globals
	input flow_cfg_t cfg_in,
	input wire logic [15:0] tpid_in,
	input wire logic backbone_in,
	// Parsed header
	input frame_hdr_t hdr_in,
	// Result
	output logic hit_out
);
	function automatic logic tag_ok(input vlan_tag_t t, input logic kind, input logic [11:0] val,
		input logic [11:0] care, input logic [15:0] tpid);
		tag_ok = (kind ? (t.tpid == tpid) : (t.tpid == `CTAG_TPID))
			&& (((t.info[11:0] ^ val) & care) == 12'h000);
	endfunction : tag_ok

	// Top bit stands for the group bit of the address
	function automatic logic addr_hit(input logic [47:0] a, input logic [2:0] kind, input logic [47:0] val);
		addr_hit = (kind[0] && (a == val)) || (kind[1] && !a[47]) || (kind[2] && a[47]);
	endfunction : addr_hit

	wire logic count_ok = hdr_in.tag_count == cfg_in.expected_tag_count;
	wire logic t1_ok = tag_ok(hdr_in.tag1, cfg_in.first_tag_kind, cfg_in.first_tag_value,
		cfg_in.first_tag_care_bits, tpid_in);
	wire logic t2_ok = tag_ok(hdr_in.tag2, cfg_in.second_tag_kind, cfg_in.second_tag_value,
		cfg_in.second_tag_care_bits, tpid_in);
	wire logic plain_ok = !cfg_in.tag_value_check_on || (count_ok
		&& (cfg_in.expected_tag_count == 2'h0 || t1_ok)
		&& (cfg_in.expected_tag_count < 2'h2 || t2_ok));
	wire vlan_tag_t itag = cfg_in.first_tag_kind ? hdr_in.tag1 : hdr_in.tag2;
	wire logic itag_ok = (itag.tpid == `ITAG_TPID)
		&& (itag.info == {cfg_in.tag_range_high, cfg_in.tag_range_low});
	wire logic shape_ok = cfg_in.first_tag_kind ? (hdr_in.tag_count == 2'h1)
		: (hdr_in.tag_count == 2'h2);
	wire logic pbb_vals_ok = !cfg_in.tag_value_check_on || cfg_in.first_tag_kind
		|| tag_ok(hdr_in.tag1, 1'b1, cfg_in.first_tag_value, cfg_in.first_tag_care_bits, tpid_in);
	wire logic tags_ok = backbone_in ? (shape_ok && itag_ok && pbb_vals_ok) : plain_ok;
	wire logic is_length = hdr_in.type_len < `LENGTH_LIMIT;
	wire logic etype_ok = cfg_in.length_type_handling ? (is_length == hdr_in.snap_llc_seen)
		: (!is_length && !hdr_in.snap_llc_seen);
	wire logic da_hit = addr_hit(hdr_in.dest_addr, cfg_in.station_addr_kind, cfg_in.station_addr_value);
	wire logic sa_hit = addr_hit(hdr_in.src_addr, cfg_in.station_addr_kind, cfg_in.station_addr_value);
	logic addr_ok;
	always_comb begin
		unique case (cfg_in.station_addr_which)
			2'h0: addr_ok = da_hit;
			2'h1: addr_ok = sa_hit;
			2'h2: addr_ok = da_hit || sa_hit;
			2'h3: addr_ok = 1'b0;
		endcase
		if (cfg_in.station_addr_kind == 3'h0) begin
			addr_ok = 1'b1;
		end
	end
	wire logic [11:0] range_vid = (cfg_in.tag_range_select == 2'h1) ? hdr_in.tag1.info[11:0]
		: hdr_in.tag2.info[11:0];
	wire logic range_on = !backbone_in && (cfg_in.tag_range_select == 2'h1 || cfg_in.tag_range_select == 2'h2);
	wire logic range_ok = !range_on || (range_vid >= cfg_in.tag_range_low
		&& range_vid <= cfg_in.tag_range_high);
	wire logic applies = cfg_in.flow_slot_on && cfg_in.flow_lane_select[hdr_in.lane];

	assign hit_out = applies && tags_ok && etype_ok && addr_ok && range_ok;
endmodule : flow_match_unit

/* verilog/ethernet_flow_classifier.sv */
// Purpose: Per-flow Ethernet header classifier with its register port
// Assumes: Parser presents one header per valid cycle; register port is never stalled
// Notes: One cycle from header valid to the registered flow hits
module ethernet_flow_classifier import flow_pkg::*; #(
	parameter bit BACKBONE_CAPABLE = 1'b1
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Parsed frame header
	input frame_hdr_t hdr_in,
	// Classification result
	output logic [`FLOWS-1:0] flow_hit_out,
	output logic result_valid_out,
	output logic result_lane_out
);
	localparam int NF = `FLOWS;

	// Reset release through two stages
	logic [1:0] rst_sync_q;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	wire logic rstn_q = rst_sync_q[1];

	function automatic flow_cfg_t put_word(input flow_cfg_t c, input logic [2:0] w, input logic [31:0] d);
		flow_cfg_t r;
		r = c;
		unique case (w)
			`W_CTRL: begin
				r.flow_slot_on = d[`CTRL_ON_BIT];
				r.flow_lane_select = d[`CTRL_LANE_LSB +: `LANES];
				r.expected_tag_count = d[`CTRL_COUNT_LSB +: 2];
				r.first_tag_kind = d[`CTRL_K1_BIT];
				r.second_tag_kind = d[`CTRL_K2_BIT];
				r.length_type_handling = d[`CTRL_LT_BIT];
				r.tag_value_check_on = d[`CTRL_VERIFY_BIT];
				r.tag_range_select = d[`CTRL_RANGE_LSB +: 2];
				r.station_addr_which = d[`CTRL_WHICH_LSB +: 2];
				r.station_addr_kind = d[`CTRL_KIND_LSB +: 3];
			end
			`W_ADDR_LO: r.station_addr_value[31:0] = d;
			`W_ADDR_HI: r.station_addr_value[47:32] = d[15:0];
			`W_FIRST: begin
				r.first_tag_value = d[11:0];
				r.first_tag_care_bits = d[`HI_LSB +: 12];
			end
			`W_SECOND: begin
				r.second_tag_value = d[11:0];
				r.second_tag_care_bits = d[`HI_LSB +: 12];
			end
			`W_RANGE: begin
				r.tag_range_low = d[11:0];
				r.tag_range_high = d[`HI_LSB +: 12];
			end
			default: r = c;
		endcase
		put_word = r;
	endfunction : put_word

	function automatic logic [31:0] get_word(input flow_cfg_t c, input logic [2:0] w);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (w)
			`W_CTRL: begin
				d[`CTRL_ON_BIT] = c.flow_slot_on;
				d[`CTRL_LANE_LSB +: `LANES] = c.flow_lane_select;
				d[`CTRL_COUNT_LSB +: 2] = c.expected_tag_count;
				d[`CTRL_K1_BIT] = c.first_tag_kind;
				d[`CTRL_K2_BIT] = c.second_tag_kind;
				d[`CTRL_LT_BIT] = c.length_type_handling;
				d[`CTRL_VERIFY_BIT] = c.tag_value_check_on;
				d[`CTRL_RANGE_LSB +: 2] = c.tag_range_select;
				d[`CTRL_WHICH_LSB +: 2] = c.station_addr_which;
				d[`CTRL_KIND_LSB +: 3] = c.station_addr_kind;
			end
			`W_ADDR_LO: d = c.station_addr_value[31:0];
			`W_ADDR_HI: d[15:0] = c.station_addr_value[47:32];
			`W_FIRST: d = {4'h0, c.first_tag_care_bits, 4'h0, c.first_tag_value};
			`W_SECOND: d = {4'h0, c.second_tag_care_bits, 4'h0, c.second_tag_value};
			`W_RANGE: d = {4'h0, c.tag_range_high, 4'h0, c.tag_range_low};
			default: d = 32'h0000_0000;
		endcase
		get_word = d;
	endfunction : get_word

	// Address decode
	wire logic aligned = reg_addr_in[1:0] == 2'b00;
	wire logic [3:0] slot = reg_addr_in[8:5];
	// Slots past the last flow would alias onto flows 0 to 5 through the 3-bit index
	wire logic in_flows = aligned && (reg_addr_in >= `FLOW_BASE) && (slot < 4'(`FLOW_SLOT_FIRST + `FLOWS));
	wire logic [2:0] flow_idx = 3'(slot - `FLOW_SLOT_FIRST);
	wire logic [2:0] word_idx = reg_addr_in[4:2];
	wire logic hit_global = aligned && (reg_addr_in == `GLOBAL_OFS);
	wire logic hit_status = aligned && (reg_addr_in == `STATUS_OFS);

	// Configuration store and global state
	flow_cfg_t cfg_q [NF];
	wire flow_cfg_t cfg_d [NF];
	logic [15:0] tpid_q;
	logic pbb_q;
	logic [`FLOWS-1:0] hit_q;
	logic valid_q;
	logic lane_q;
	logic [15:0] frames_q;
	logic [31:0] rdata_q;

	wire logic wr_global = reg_wr_in && hit_global;
	wire logic [15:0] tpid_d = wr_global ? reg_wdata_in[15:0] : tpid_q;
	wire logic pbb_d = wr_global ? reg_wdata_in[`GLB_PBB_BIT] : pbb_q;
	// Second comparator instances tie the bit off so it reads zero too
	wire logic backbone_on = pbb_q && BACKBONE_CAPABLE;

	wire logic [`FLOWS-1:0] hit_d;
	genvar g;
	generate
		for (g = 0; g < NF; g++) begin : g_flow
			assign cfg_d[g] = (reg_wr_in && in_flows && flow_idx == 3'(g))
				? put_word(cfg_q[g], word_idx, reg_wdata_in) : cfg_q[g];
			flow_match_unit u_match (
				.cfg_in(cfg_q[g]),
				.tpid_in(tpid_q),
				.backbone_in(backbone_on),
				.hdr_in(hdr_in),
				.hit_out(hit_d[g])
			);
		end
	endgenerate

	wire logic [31:0] global_word = {15'h0000, backbone_on, tpid_q};
	wire logic [31:0] status_word = {frames_q, 7'h00, lane_q, hit_q};
	wire logic [31:0] flow_word = get_word(cfg_q[flow_idx], word_idx);
	wire logic [31:0] rd_mux = hit_global ? global_word
		: hit_status ? status_word
		: in_flows ? flow_word : 32'h0000_0000;
	wire logic [31:0] rdata_d = reg_rd_in ? rd_mux : 32'h0000_0000;
	wire logic [`FLOWS-1:0] hit_next = hdr_in.valid ? hit_d : {`FLOWS{1'b0}};
	wire logic [15:0] frames_d = hdr_in.valid ? 16'(frames_q + 16'h0001) : frames_q;

	always_ff @(posedge clock_in or negedge rstn_q) begin
		if (!rstn_q) begin
			for (int i = 0; i < NF; i++) begin
				cfg_q[i] <= '0;
			end
			tpid_q <= `TPID_RESET;
			pbb_q <= `PBB_RESET;
		end else begin
			for (int i = 0; i < NF; i++) begin
				cfg_q[i] <= cfg_d[i];
			end
			tpid_q <= tpid_d;
			pbb_q <= pbb_d;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_q) begin
		if (!rstn_q) begin
			hit_q <= '0;
			valid_q <= 1'b0;
			lane_q <= 1'b0;
			frames_q <= 16'h0000;
			rdata_q <= 32'h0000_0000;
		end else begin
			hit_q <= hit_next;
			valid_q <= hdr_in.valid;
			lane_q <= hdr_in.valid ? hdr_in.lane : lane_q;
			frames_q <= frames_d;
			rdata_q <= rdata_d;
		end
	end

	assign flow_hit_out = hit_q;
	assign result_valid_out = valid_q;
	assign result_lane_out = lane_q;
	assign reg_rdata_out = rdata_q;

	// Checks on flow set 0, the backbone tie-off and read data timing
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_q);

	wire flow_cfg_t c0 = cfg_q[0];
	wire logic hv = hdr_in.valid;

	sequence s_hdr_seen;
		hv;
	endsequence
	sequence s_no_hit0;
		!flow_hit_out[0] && result_valid_out;
	endsequence

	a_disabled_no_hit: assert property (s_hdr_seen and !c0.flow_slot_on |=> s_no_hit0)
		else $error("disabled flow reported a hit");
	a_lane_masked_out: assert property (hv && !c0.flow_lane_select[hdr_in.lane] |=> s_no_hit0)
		else $error("flow hit on a lane it does not serve");
	a_tag_count_check: assert property (hv && !backbone_on && c0.tag_value_check_on
		&& hdr_in.tag_count != c0.expected_tag_count |=> s_no_hit0)
		else $error("wrong tag count accepted");
	a_type2_only: assert property (hv && !c0.length_type_handling
		&& hdr_in.type_len < `LENGTH_LIMIT |=> s_no_hit0)
		else $error("length frame accepted in type 2 mode");
	a_snap_needed: assert property (hv && c0.length_type_handling && hdr_in.type_len < `LENGTH_LIMIT
		&& !hdr_in.snap_llc_seen |=> s_no_hit0)
		else $error("type 1 frame without SNAP/LLC accepted");
	a_reserved_select: assert property (hv && c0.station_addr_which == 2'h3
		&& c0.station_addr_kind != 3'h0 |=> s_no_hit0)
		else $error("reserved address select matched");
	a_multicast_only: assert property (hv && c0.station_addr_kind == 3'h4
		&& c0.station_addr_which == 2'h0 && !hdr_in.dest_addr[47] |=> s_no_hit0)
		else $error("unicast address passed multicast mode");
	a_first_mask: assert property (hv && !backbone_on && c0.tag_value_check_on
		&& c0.expected_tag_count != 2'h0
		&& ((hdr_in.tag1.info[11:0] ^ c0.first_tag_value) & c0.first_tag_care_bits) != 12'h000
		|=> s_no_hit0)
		else $error("masked first tag mismatch accepted");
	a_range_high: assert property (hv && !backbone_on && c0.tag_range_select == 2'h1
		&& hdr_in.tag1.info[11:0] > c0.tag_range_high |=> s_no_hit0)
		else $error("identifier above range accepted");
	a_itag_sid: assert property (hv && backbone_on && !c0.first_tag_kind
		&& hdr_in.tag2.info != {c0.tag_range_high, c0.tag_range_low} |=> s_no_hit0)
		else $error("I-tag service identifier mismatch accepted");
	a_hit_needs_frame: assert property (flow_hit_out[0] |-> result_valid_out && $past(hv)
		&& $past(c0.flow_slot_on))
		else $error("hit without an enabled frame");
	a_second_no_pbb: assert property (!BACKBONE_CAPABLE |-> !global_word[`GLB_PBB_BIT])
		else $error("backbone mode active in second comparator");
	a_read_one_cycle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
		else $error("read data outside its cycle");
endmodule : ethernet_flow_classifier

/* verification/hdr_source.sv */
// Purpose: Upstream parser model presenting one queued header per clock
// Assumes: The bench fills q; headers leave back to back
// Notes: Idle cycles show fields that change every cycle, never stale ones
module hdr_source import flow_pkg::*; (
	// Clock
	input wire logic clock_in,
	// Parsed header
	output frame_hdr_t hdr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	frame_hdr_t q[$];
	frame_hdr_t last = '0;
	frame_hdr_t nxt;
	initial hdr_out = '0;
	always @(posedge clock_in) begin
		if (q.size() > 0) begin
			nxt = q.pop_front();
			nxt.valid = 1'b1;
			last = nxt;
		end else begin
			last = ~last;
			nxt = last;
			nxt.valid = 1'b0;
		end
		hdr_out <= nxt;
	end
endmodule : hdr_source

/* verification/test_ethernet_flow_classifier.sv */
// Purpose: Random and corner-case check of the flow classifier, with and without backbone
// Assumes: Register port never stalls; results one cycle after each header
// Notes: A second copy built without backbone sees the same traffic
`include "flow_cfg.svh"
module test_ethernet_flow_classifier import flow_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] h1; logic [7:0] h0; logic lane;} exp_t;
	localparam logic [47:0] ADDR_A = 48'h0000_0000_00a0;
	localparam logic [47:0] ADDR_B = 48'h8000_0000_00a1;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [`ADDR_W-1:0] reg_addr_in = '0;
	logic [31:0] reg_wdata_in = '0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] rdata1, rdata0;
	frame_hdr_t hdr, dh;
	logic [`FLOWS-1:0] hit1, hit0;
	logic rv1, rv0, rl1, rl0;
	flow_cfg_t cfg [`FLOWS];
	exp_t expq[$];
	exp_t e, m;
	integer seed = 93;
	int mismatches = 0;
	int compares = 0;
	logic run = 1'b0;
	logic pv = 1'b0;
	logic pbb = 1'b0;
	logic [15:0] tpid = 16'h88a8;
	logic [15:0] hcnt = '0;

	initial forever #2 clock_in = ~clock_in;
	hdr_source hdr_source_i (.clock_in(clock_in), .hdr_out(hdr));
	ethernet_flow_classifier #(.BACKBONE_CAPABLE(1'b1)) ethernet_flow_classifier_i (.clock_in(clock_in),
		.rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata1), .hdr_in(hdr), .flow_hit_out(hit1),
		.result_valid_out(rv1), .result_lane_out(rl1));
	ethernet_flow_classifier #(.BACKBONE_CAPABLE(1'b0)) ethernet_flow_classifier_nb_i (.clock_in(clock_in),
		.rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata0), .hdr_in(hdr), .flow_hit_out(hit0),
		.result_valid_out(rv0), .result_lane_out(rl0));

	function automatic logic [31:0] rnd(input logic [31:0] n);
		return $unsigned($random(seed)) % n;
	endfunction : rnd
	function automatic logic addr_ok(flow_cfg_t c, logic [47:0] x);
		return (c.station_addr_kind[0] && x == c.station_addr_value) || (c.station_addr_kind[1] && !x[47])
			|| (c.station_addr_kind[2] && x[47]);
	endfunction : addr_ok
	function automatic logic tag_ok(vlan_tag_t t, logic k, logic [11:0] v, logic [11:0] msk);
		return t.tpid == (k ? tpid : `CTAG_TPID) && ((t.info[11:0] ^ v) & msk) == 12'h0;
	endfunction : tag_ok
	function automatic logic flow_hit(flow_cfg_t c, frame_hdr_t h, logic bb);
		vlan_tag_t it;
		logic [11:0] id;
		logic a, t, g, r;
		a = c.station_addr_kind == 3'h0 || (c.station_addr_which != 2'h1 && addr_ok(c, h.dest_addr))
			|| (c.station_addr_which != 2'h0 && addr_ok(c, h.src_addr));
		t = c.length_type_handling ? ((h.type_len < `LENGTH_LIMIT) == h.snap_llc_seen)
			: (h.type_len >= `LENGTH_LIMIT && !h.snap_llc_seen);
		id = c.tag_range_select == 2'h1 ? h.tag1.info[11:0] : h.tag2.info[11:0];
		r = bb || !(c.tag_range_select inside {2'h1, 2'h2}) || (id >= c.tag_range_low && id <= c.tag_range_high);
		it = c.first_tag_kind ? h.tag1 : h.tag2;
		if (bb) begin
			g = it.tpid == `ITAG_TPID && it.info == {c.tag_range_high, c.tag_range_low}
				&& h.tag_count == (c.first_tag_kind ? 2'h1 : 2'h2) && (!c.tag_value_check_on || c.first_tag_kind
				|| tag_ok(h.tag1, 1'b1, c.first_tag_value, c.first_tag_care_bits));
		end else begin
			g = !c.tag_value_check_on || (h.tag_count == c.expected_tag_count
				&& (c.expected_tag_count == 2'h0 || tag_ok(h.tag1, c.first_tag_kind, c.first_tag_value,
				c.first_tag_care_bits)) && (c.expected_tag_count != 2'h2 || tag_ok(h.tag2, c.second_tag_kind,
				c.second_tag_value, c.second_tag_care_bits)));
		end
		return c.flow_slot_on && c.flow_lane_select[h.lane] && a && t && g && r;
	endfunction : flow_hit
	function automatic logic [7:0] hits(frame_hdr_t h, logic bb);
		for (int f = 0; f < `FLOWS; f++) hits[f] = flow_hit(cfg[f], h, bb);
	endfunction : hits
	function automatic vlan_tag_t rand_tag();
		logic [31:0] k;
		k = rnd(3);
		rand_tag.tpid = k == 0 ? `CTAG_TPID : (k == 1 ? tpid : `ITAG_TPID);
		rand_tag.info = {12'(rnd(8)), 12'(rnd(8))};
	endfunction : rand_tag
	function automatic logic [47:0] rand_addr();
		logic [31:0] k;
		k = rnd(3);
		return k == 0 ? ADDR_A : (k == 1 ? ADDR_B : 48'({$random(seed), $random(seed)}));
	endfunction : rand_addr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [31:0] x1, input logic [31:0] x0);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(rdata1, x1, "read data");
		chk(rdata0, x0, "read data second copy");
		@(posedge clock_in);
		#1;
		chk(rdata1 | rdata0, 32'h0, "read data not cleared");
	endtask : rd
	task automatic put_flow(input int f);
		logic [8:0] b;
		logic [31:0] w [6];
		flow_cfg_t c;
		c = cfg[f];
		b = 9'(`FLOW_BASE + `FLOW_STRIDE * f);
		w[0] = {16'h0, c.station_addr_kind, c.station_addr_which, c.tag_range_select, c.tag_value_check_on,
			c.length_type_handling, c.second_tag_kind, c.first_tag_kind, c.expected_tag_count,
			c.flow_lane_select, c.flow_slot_on};
		w[1] = c.station_addr_value[31:0];
		w[2] = {16'h0, c.station_addr_value[47:32]};
		w[3] = {4'h0, c.first_tag_care_bits, 4'h0, c.first_tag_value};
		w[4] = {4'h0, c.second_tag_care_bits, 4'h0, c.second_tag_value};
		w[5] = {4'h0, c.tag_range_high, 4'h0, c.tag_range_low};
		for (int i = 0; i < 6; i++) wr(b + 9'(4 * i), w[i]);
		for (int i = 0; i < 6; i++) rd(b + 9'(4 * i), w[i], w[i]);
	endtask : put_flow
	task automatic push(input frame_hdr_t h);
		e.h1 = hits(h, pbb);
		e.h0 = hits(h, 1'b0);
		e.lane = h.lane;
		expq.push_back(e);
		hdr_source_i.q.push_back(h);
		hcnt++;
	endtask : push
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	always @(posedge clock_in) begin
		if (run) begin
			m = pv ? expq.pop_front() : '0;
			chk({30'h0, rv1, rv0}, {30'h0, pv, pv}, "result valid");
			chk({24'h0, hit1}, {24'h0, m.h1}, "flow hits");
			chk({24'h0, hit0}, {24'h0, m.h0}, "flow hits second copy");
			if (pv) chk({30'h0, rl1, rl0}, {30'h0, m.lane, m.lane}, "result lane");
		end
		pv = hdr.valid;
	end

	initial begin
		#40000;
		mismatches++;
		$display("FAIL %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		repeat (20) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		run = 1'b1;
		rd(`GLOBAL_OFS, {15'h0, `PBB_RESET, `TPID_RESET}, 32'h0);
		rd(`FLOW_BASE, 32'h0, 32'h0);
		wr(`FLOW_BASE + 9'h01c, 32'hffffffff);
		rd(`FLOW_BASE + 9'h01c, 32'h0, 32'h0);
		wr(9'h140, 32'hffffffff);
		rd(`FLOW_BASE, 32'h0, 32'h0);
		rd(9'h140, 32'h0, 32'h0);
		for (int ph = 0; ph < 2; ph++) begin
			pbb = ph[0];
			wr(`GLOBAL_OFS, {15'h0, pbb, tpid});
			rd(`GLOBAL_OFS, {15'h0, pbb, tpid}, {16'h0, tpid});
			for (int f = 0; f < `FLOWS; f++) begin
				cfg[f] = '0;
				cfg[f].flow_slot_on = rnd(5) != 0;
				cfg[f].flow_lane_select = 2'(rnd(4));
				cfg[f].expected_tag_count = 2'(rnd(3));
				{cfg[f].first_tag_kind, cfg[f].second_tag_kind} = 2'(rnd(4));
				{cfg[f].length_type_handling, cfg[f].tag_value_check_on} = 2'(rnd(4));
				cfg[f].tag_range_select = 2'(rnd(4));
				cfg[f].station_addr_which = 2'(rnd(3));
				cfg[f].station_addr_kind = 3'(rnd(8));
				cfg[f].station_addr_value = rnd(2) ? ADDR_A : ADDR_B;
				cfg[f].first_tag_value = 12'(rnd(8));
				cfg[f].first_tag_care_bits = (cfg[f].expected_tag_count != 2'h0 || pbb) ? 12'(rnd(8)) : 12'h0;
				cfg[f].second_tag_value = 12'(rnd(8));
				cfg[f].second_tag_care_bits = (cfg[f].expected_tag_count == 2'h2 && !pbb) ? 12'(rnd(8)) : 12'h0;
				{cfg[f].tag_range_high, cfg[f].tag_range_low} = {12'(rnd(8)), 12'(rnd(8))};
			end
			if (pbb) begin
				cfg[0] = '0;
				{cfg[0].flow_slot_on, cfg[0].flow_lane_select, cfg[0].first_tag_kind} = 4'hf;
				cfg[0].tag_value_check_on = 1'b1;
				{cfg[0].tag_range_high, cfg[0].tag_range_low} = 24'h123456;
			end
			for (int f = 0; f < `FLOWS; f++) put_flow(f);
			if (pbb) begin
				dh = '0;
				dh.tag_count = 2'h1;
				dh.tag1 = {`ITAG_TPID, 24'h123456};
				dh.type_len = 16'h0800;
				push(dh);
				dh.tag1.info = 24'h123457;
				push(dh);
			end
			for (int i = 0; i < 150; i++) begin
				dh = '0;
				dh.lane = 1'(rnd(2));
				dh.dest_addr = rand_addr();
				dh.src_addr = rand_addr();
				dh.tag_count = 2'(rnd(3));
				dh.tag1 = rand_tag();
				dh.tag2 = rand_tag();
				dh.type_len = 16'h05fe + 16'(rnd(4));
				dh.snap_llc_seen = 1'(rnd(2));
				push(dh);
			end
			for (int i = 0; i < 400 && expq.size() > 0; i++) @(posedge clock_in);
			// Hits in the status word follow the result: zero once traffic has gone idle
			rd(`STATUS_OFS, {hcnt, 7'h0, e.lane, 8'h00}, {hcnt, 7'h0, e.lane, 8'h00});
		end
		test_done();
	end
endmodule : test_ethernet_flow_classifier
